// ===== inc/phcp_pkg.sv
// Purpose: Shared constants and types for the parallel host control port.
// Assumes: 8-bit host bus, 8-bit register address space.
// Notes: Offsets of the status, mask and user output registers are fixed here.
package phcp_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int LO_ADDR_W = 7;
  localparam int EVENT_W = 8;
  localparam int UOP_W = 4;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_UOP_CTRL = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_INT_MASK = 8'h21;

  // Field positions
  localparam int UOP_LSB = 0;

  // Reset values: every configuration register clears to zero
  localparam logic [DATA_W-1:0] RST_REG = 8'h00;
  localparam logic [UOP_W-1:0] RST_UOP = 4'h0;

  // Synchronised pin bundle
  typedef struct packed {
    logic tst;
    logic mux;
    logic style;
    logic cs_n;
    logic rds;
    logic ale;
    logic wrp;
    logic sel;
    logic [LO_ADDR_W-1:0] lo_addr;
    logic [DATA_W-1:0] ad;
  } phcp_pins_t;

  localparam phcp_pins_t PINS_IDLE = '{
    tst: 1'b0, mux: 1'b0, style: 1'b0, cs_n: 1'b1, rds: 1'b1, ale: 1'b0,
    wrp: 1'b1, sel: 1'b0, lo_addr: 7'h00, ad: 8'h00};

  // One committed register write
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } phcp_wr_t;
endpackage

// ===== logic/phcp_regfile.sv
// Purpose: Byte-wide configuration register store with registered read data.
// Assumes: One write port, one read port, single clock.
// Notes: clr_i zeroes every entry in one cycle; it wins over a write.
`timescale 1ns/10ps
`default_nettype none
module phcp_regfile #(
  parameter int AW = phcp_pkg::ADDR_W,
  parameter int DW = phcp_pkg::DATA_W
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Control
  input wire logic clr_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  // Read
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);
  localparam int DEPTH = 1 << AW;
  logic [DW-1:0] mem_q [DEPTH];

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_entry
      always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          mem_q[g] <= phcp_pkg::RST_REG;
        end else if (clr_i) begin
          mem_q[g] <= phcp_pkg::RST_REG;
        end else if (we_i && (waddr_i == AW'(g))) begin
          mem_q[g] <= wdata_i;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_o <= phcp_pkg::RST_REG;
    end else begin
      rdata_o <= mem_q[raddr_i];
    end
  end
endmodule
`default_nettype wire

// ===== logic/phcp_top.sv
// Purpose: Strobe-based 8-bit host control port with straps, interrupt and user outputs.
// Assumes: All host pins are asynchronous to ref_clk_i and held for several clocks.
// Notes: Strobes are oversampled; the host timing must allow the filter latency.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Interrupt pin pulled low while an unmasked status bit is set; never driven high.
// - A rising edge on the tri-state/reset pin resets the register set.
// - Reset clears every configuration register to zero.
// - While tri-state/reset pin is high every output except the backplane selects floats; host keeps it low.
// - Multiplex strap low selects separate buses, high selects a shared bus.
// - Bus pins carry data only when separate, address then data when shared.
// - Separate mode takes low address pins; shared mode ignores them.
// - In separate mode the latch pin is the top address bit.
// - In shared mode the address is captured on the latch rising edge.
// - Bus style strap picks strobe/direction timing or read/write strobe timing.
// - Style strap high turns read, latch, write into data strobe, strobe, direction.
// - Read and data strobe active low, except data strobe active high when shared.
// - Strobes are ignored while chip select is high.
// - Write strobe is active low; the write is committed when it returns high.
// - Backplane select low picks the TDM backplane, high the UTOPIA one.
// - User output pins follow bits 0 to 3 of the user output register.
// - User output pins are low after power-up and any reset.
module phcp_top #(
  parameter int EW = phcp_pkg::EVENT_W
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Straps and control pins
  input wire logic tristate_reset_pin_i,
  input wire logic mux_strap_i,
  input wire logic bus_style_strap_i,
  input wire logic chip_select_n_i,
  input wire logic read_or_data_strobe_i,
  input wire logic addr_latch_or_top_addr_bit_i,
  input wire logic write_or_direction_i,
  input wire logic backplane_select_i,
  // Host address and data
  input wire logic [phcp_pkg::LO_ADDR_W-1:0] low_address_pins_i,
  input wire logic [phcp_pkg::DATA_W-1:0] shared_addr_data_bus_i,
  output logic [phcp_pkg::DATA_W-1:0] shared_addr_data_bus_o,
  output logic shared_addr_data_bus_oe_o,
  // Interrupt, open drain
  output logic interrupt_n_o,
  output logic interrupt_n_oe_o,
  // Device events and backplane mode
  input wire logic [EW-1:0] event_i,
  output logic utopia_backplane_o,
  output logic tdm_backplane_o,
  // User outputs
  output logic [phcp_pkg::UOP_W-1:0] user_output_pins_o,
  output logic user_output_pins_oe_o
);
  localparam int AW = phcp_pkg::ADDR_W;
  localparam int DW = phcp_pkg::DATA_W;

  phcp_pkg::phcp_pins_t pins_raw;
  phcp_pkg::phcp_pins_t sync1_q, sync2_q, sync3_q, pins_q;
  logic tst_prev_q, ale_prev_q, clr_pulse;
  logic act, is_read, wr_pend_q;
  logic [AW-1:0] addr_lat_q, addr_eff;
  phcp_pkg::phcp_wr_t wr_q;
  logic wr_commit;
  logic [DW-1:0] status_q, mask_q, user_ctrl_q;
  logic [DW-1:0] mem_rdata, spec_val_q;
  logic spec_hit_q;
  logic mem_we;

  assign pins_raw = '{
    tst: tristate_reset_pin_i, mux: mux_strap_i, style: bus_style_strap_i,
    cs_n: chip_select_n_i, rds: read_or_data_strobe_i,
    ale: addr_latch_or_top_addr_bit_i, wrp: write_or_direction_i,
    sel: backplane_select_i, lo_addr: low_address_pins_i,
    ad: shared_addr_data_bus_i};

  // Three-stage synchroniser; stage one feeds only stage two
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync1_q <= phcp_pkg::PINS_IDLE;
      sync2_q <= phcp_pkg::PINS_IDLE;
      sync3_q <= phcp_pkg::PINS_IDLE;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // A bit moves only when stages two and three agree, which rejects a lone glitch
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pins_q <= phcp_pkg::PINS_IDLE;
    end else begin
      pins_q <= (sync2_q & sync3_q) | (pins_q & (sync2_q | sync3_q));
    end
  end

  // Edge history of the tri-state/reset and latch pins
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tst_prev_q <= 1'b0;
      ale_prev_q <= 1'b0;
    end else begin
      tst_prev_q <= pins_q.tst;
      ale_prev_q <= pins_q.ale;
    end
  end

  assign clr_pulse = pins_q.tst && !tst_prev_q;

  // Strobe decode by bus style and multiplex mode
  always_comb begin
    act = 1'b0;
    is_read = 1'b0;
    if (pins_q.style) begin
      // Data strobe polarity flips in shared mode; write pin is direction
      act = pins_q.mux ? pins_q.rds : !pins_q.rds;
      is_read = pins_q.wrp;
    end else begin
      act = !pins_q.rds || !pins_q.wrp;
      is_read = !pins_q.rds;
    end
    if (pins_q.cs_n || pins_q.tst) begin
      act = 1'b0;
    end
  end

  // Shared mode latches the address on the rising latch edge
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      addr_lat_q <= '0;
    end else if (pins_q.mux && pins_q.ale && !ale_prev_q) begin
      addr_lat_q <= pins_q.ad;
    end
  end

  // Separate mode: latch pin is the top bit; shared mode ignores the low pins
  assign addr_eff = pins_q.mux ? addr_lat_q : {pins_q.ale, pins_q.lo_addr};

  // Write capture: data tracked while the strobe is active, committed at its end
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_pend_q <= 1'b0;
      wr_q <= '0;
    end else begin
      if (act && !is_read) begin
        wr_pend_q <= 1'b1;
        wr_q.addr <= addr_eff;
        wr_q.data <= pins_q.ad;
      end else if (!act) begin
        wr_pend_q <= 1'b0;
      end
    end
  end

  // Commit also dropped if a tri-state reset arrives mid-cycle
  assign wr_commit = wr_pend_q && !act && !clr_pulse;

  assign mem_we = wr_commit && (wr_q.addr != phcp_pkg::OFS_STATUS) &&
                  (wr_q.addr != phcp_pkg::OFS_INT_MASK) &&
                  (wr_q.addr != phcp_pkg::OFS_UOP_CTRL);

  phcp_regfile #(
    .AW(AW),
    .DW(DW)
  ) u_regs (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .clr_i(clr_pulse),
    .we_i(mem_we),
    .waddr_i(wr_q.addr),
    .wdata_i(wr_q.data),
    .raddr_i(addr_eff),
    .rdata_o(mem_rdata)
  );

  // Status: events set, a write of one clears; a same-cycle event wins
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      status_q <= phcp_pkg::RST_REG;
    end else if (clr_pulse) begin
      status_q <= phcp_pkg::RST_REG;
    end else if (wr_commit && wr_q.addr == phcp_pkg::OFS_STATUS) begin
      status_q <= (status_q & ~wr_q.data) | DW'(event_i);
    end else begin
      status_q <= status_q | DW'(event_i);
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mask_q <= phcp_pkg::RST_REG;
    end else if (clr_pulse) begin
      mask_q <= phcp_pkg::RST_REG;
    end else if (wr_commit && wr_q.addr == phcp_pkg::OFS_INT_MASK) begin
      mask_q <= wr_q.data;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      user_ctrl_q <= phcp_pkg::RST_REG;
    end else if (clr_pulse) begin
      user_ctrl_q <= phcp_pkg::RST_REG;
    end else if (wr_commit && wr_q.addr == phcp_pkg::OFS_UOP_CTRL) begin
      user_ctrl_q <= wr_q.data;
    end
  end

  assign user_output_pins_o = user_ctrl_q[phcp_pkg::UOP_LSB +: phcp_pkg::UOP_W];

  // Flop-held registers are sampled one cycle early to line up with the store
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      spec_hit_q <= 1'b0;
      spec_val_q <= phcp_pkg::RST_REG;
    end else begin
      spec_hit_q <= 1'b1;
      case (addr_eff)
        phcp_pkg::OFS_STATUS: spec_val_q <= status_q;
        phcp_pkg::OFS_INT_MASK: spec_val_q <= mask_q;
        phcp_pkg::OFS_UOP_CTRL: spec_val_q <= user_ctrl_q;
        default: begin
          spec_hit_q <= 1'b0;
          spec_val_q <= phcp_pkg::RST_REG;
        end
      endcase
    end
  end

  // Data pins driven only during a selected read
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      shared_addr_data_bus_o <= phcp_pkg::RST_REG;
      shared_addr_data_bus_oe_o <= 1'b0;
    end else begin
      shared_addr_data_bus_o <= spec_hit_q ? spec_val_q : mem_rdata;
      shared_addr_data_bus_oe_o <= act && is_read;
    end
  end

  // Open drain: the level flop stays low, only the enable moves
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      interrupt_n_o <= 1'b0;
      interrupt_n_oe_o <= 1'b0;
    end else begin
      interrupt_n_o <= 1'b0;
      interrupt_n_oe_o <= (|(status_q & mask_q)) && !pins_q.tst;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      user_output_pins_oe_o <= 1'b0;
      utopia_backplane_o <= 1'b0;
      tdm_backplane_o <= 1'b1;
    end else begin
      user_output_pins_oe_o <= !pins_q.tst;
      utopia_backplane_o <= pins_q.sel;
      tdm_backplane_o <= !pins_q.sel;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  int_assert_a: assert property ((|(status_q & mask_q)) && !pins_q.tst |=>
    interrupt_n_oe_o && !interrupt_n_o)
    else $error("interrupt not pulled low for unmasked status");

  int_release_a: assert property (!(|(status_q & mask_q)) |=> !interrupt_n_oe_o)
    else $error("interrupt pulled low with nothing pending");

  rst_clear_a: assert property (clr_pulse |=>
    user_ctrl_q == phcp_pkg::RST_REG && mask_q == phcp_pkg::RST_REG)
    else $error("registers not cleared after tri-state reset edge");

  uop_low_a: assert property (clr_pulse |=> user_output_pins_o == phcp_pkg::RST_UOP)
    else $error("user outputs not low after reset");

  mem_clear_a: assert property (clr_pulse ##1 !wr_commit |=>
    spec_hit_q || mem_rdata == phcp_pkg::RST_REG)
    else $error("stored register not zero after reset");

  tri_float_a: assert property (pins_q.tst |=>
    !shared_addr_data_bus_oe_o && !interrupt_n_oe_o && !user_output_pins_oe_o)
    else $error("pins driven while tri-stated");

  addr_latch_a: assert property (pins_q.mux && $rose(pins_q.ale) |=>
    addr_lat_q == $past(pins_q.ad))
    else $error("shared-mode address not latched on rising edge");

  sep_addr_a: assert property (!pins_q.mux && act && !is_read |=>
    wr_q.addr == {$past(pins_q.ale), $past(pins_q.lo_addr)})
    else $error("separate-mode address not taken from pins");

  pin_filter_a: assert property (sync2_q == sync3_q |=> pins_q == $past(sync3_q))
    else $error("filtered pins do not follow agreeing stages");

  cs_ignore_a: assert property (pins_q.cs_n |=> !shared_addr_data_bus_oe_o)
    else $error("bus driven without chip select");

  ds_polarity_a: assert property (pins_q.style && pins_q.mux && !pins_q.cs_n &&
    !pins_q.tst && pins_q.rds && pins_q.wrp |=> shared_addr_data_bus_oe_o)
    else $error("active-high data strobe read not answered");

  strobe_wr_a: assert property (!pins_q.style && !pins_q.cs_n && !pins_q.tst &&
    !pins_q.wrp && pins_q.rds |=> wr_pend_q)
    else $error("low write strobe did not start a write");

  uop_follow_a: assert property (wr_commit && wr_q.addr == phcp_pkg::OFS_UOP_CTRL |=>
    user_output_pins_o == $past(wr_q.data[3:0]))
    else $error("user outputs do not follow control bits");

  sel_follow_a: assert property (##1 utopia_backplane_o == $past(pins_q.sel) &&
    tdm_backplane_o != utopia_backplane_o)
    else $error("backplane select not followed");

  read_c: cover property (act && is_read ##1 shared_addr_data_bus_oe_o);
  write_c: cover property (wr_commit && wr_q.addr == phcp_pkg::OFS_UOP_CTRL);
  mux_latch_c: cover property (pins_q.mux && $rose(pins_q.ale));
  irq_c: cover property ($rose(interrupt_n_oe_o));
endmodule
`default_nettype wire

// ===== tb/phcp_host_model.sv
// Purpose: Host processor model driving the strobe-based control port pins.
// Assumes: Straps are stable before an access; accesses are one byte each.
// Notes: A released data bus shows the inverse of the last host value, never a held copy.
`timescale 1ns/10ps
`default_nettype none
module phcp_host_model (
  // Clock and straps
  input wire logic ref_clk_i,
  input wire logic mux_i,
  input wire logic style_i,
  // Device side of the data bus
  input wire logic [phcp_pkg::DATA_W-1:0] dev_data_i,
  input wire logic dev_oe_i,
  // Host pins
  output logic cs_n_o,
  output logic rds_o,
  output logic ale_o,
  output logic wrp_o,
  output logic [phcp_pkg::LO_ADDR_W-1:0] lo_addr_o,
  output logic [phcp_pkg::DATA_W-1:0] ad_o
);
  logic drv_q = 1'b0;
  logic [phcp_pkg::DATA_W-1:0] val_q = 8'h00;

  initial begin
    cs_n_o = 1'b1;
    rds_o = 1'b1;
    ale_o = 1'b0;
    wrp_o = 1'b1;
    lo_addr_o = 7'h00;
  end

  // Wire level seen by the device
  assign ad_o = dev_oe_i ? dev_data_i : (drv_q ? val_q : ~val_q);

  task automatic idle();
    rds_o <= style_i ? ~mux_i : 1'b1;
    ale_o <= 1'b0;
    wrp_o <= 1'b1;
  endtask

  task automatic access(input logic wr, input logic sel, input logic [7:0] addr,
                        input logic [7:0] wd, output logic [7:0] rd, output logic oe);
    @(posedge ref_clk_i);
    if (mux_i) begin
      lo_addr_o <= 7'h00;
      val_q <= addr;
      drv_q <= 1'b1;
      repeat (6) @(posedge ref_clk_i);
      ale_o <= 1'b1;
      repeat (6) @(posedge ref_clk_i);
      ale_o <= 1'b0;
    end else begin
      lo_addr_o <= addr[6:0];
      ale_o <= addr[7];
    end
    drv_q <= wr;
    val_q <= wd;
    cs_n_o <= ~sel;
    wrp_o <= style_i ? ~wr : 1'b1;
    repeat (6) @(posedge ref_clk_i);
    if (style_i) begin
      rds_o <= mux_i;
    end else if (wr) begin
      wrp_o <= 1'b0;
    end else begin
      rds_o <= 1'b0;
    end
    repeat (12) @(posedge ref_clk_i);
    rd = dev_data_i;
    oe = dev_oe_i;
    rds_o <= style_i ? ~mux_i : 1'b1;
    if (!style_i) begin
      wrp_o <= 1'b1;
    end
    repeat (6) @(posedge ref_clk_i);
    cs_n_o <= 1'b1;
    drv_q <= 1'b0;
    wrp_o <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
  endtask
endmodule
`default_nettype wire

// ===== tb/phcp_top_tb.sv
// Purpose: Self-checking bench for the parallel host control port.
// Assumes: Host model keeps chip select, tie-low and strap rules.
// Notes: Writes all rows first, then reads them, so address aliasing shows up.
`timescale 1ns/10ps
`default_nettype none
module phcp_top_tb;
  typedef struct packed {
    logic style;
    logic mux;
    logic [7:0] addr;
    logic [7:0] data;
  } phcp_row_t;

  localparam phcp_row_t ROWS [8] = '{
    '{1'b0, 1'b0, 8'h05, 8'ha5}, '{1'b0, 1'b0, 8'h85, 8'h5a},
    '{1'b0, 1'b1, 8'h06, 8'h3c}, '{1'b1, 1'b0, 8'h86, 8'hc3},
    '{1'b1, 1'b1, 8'h07, 8'hff}, '{1'b1, 1'b0, 8'h14, 8'h09},
    '{1'b0, 1'b1, 8'h40, 8'h00}, '{1'b1, 1'b1, 8'hc1, 8'h81}};

  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic tst = 1'b0;
  logic mux = 1'b0;
  logic style = 1'b0;
  logic bp_sel = 1'b0;
  logic [7:0] ev = 8'h00;
  logic cs_n, rds, ale, wrp;
  logic [6:0] lo_addr;
  logic [7:0] ad, dout, rd;
  logic dout_oe, int_n, int_oe, utopia, tdm, uop_oe, oe;
  logic [3:0] uop;
  int fail_count = 0;
  int total_checks = 0;
  int cycle_count = 0;

  initial begin
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  phcp_host_model i_host (.ref_clk_i(ref_clk_i), .mux_i(mux), .style_i(style),
    .dev_data_i(dout), .dev_oe_i(dout_oe), .cs_n_o(cs_n), .rds_o(rds), .ale_o(ale),
    .wrp_o(wrp), .lo_addr_o(lo_addr), .ad_o(ad));

  phcp_top i_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .tristate_reset_pin_i(tst),
    .mux_strap_i(mux), .bus_style_strap_i(style), .chip_select_n_i(cs_n),
    .read_or_data_strobe_i(rds), .addr_latch_or_top_addr_bit_i(ale),
    .write_or_direction_i(wrp), .backplane_select_i(bp_sel), .low_address_pins_i(lo_addr),
    .shared_addr_data_bus_i(ad), .shared_addr_data_bus_o(dout),
    .shared_addr_data_bus_oe_o(dout_oe), .interrupt_n_o(int_n), .interrupt_n_oe_o(int_oe),
    .event_i(ev), .utopia_backplane_o(utopia), .tdm_backplane_o(tdm),
    .user_output_pins_o(uop), .user_output_pins_oe_o(uop_oe));

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    if (fail_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic set_mode(input logic b, input logic m);
    @(posedge ref_clk_i);
    style <= b;
    mux <= m;
    repeat (8) @(posedge ref_clk_i);
    i_host.idle();
    repeat (8) @(posedge ref_clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host.access(1'b1, 1'b1, a, d, rd, oe);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
    i_host.access(1'b0, 1'b1, a, 8'h00, rd, oe);
    check(name, rd, exp);
    check("read_oe", {7'h00, oe}, 8'h01);
    check("idle_oe", {7'h00, dout_oe}, 8'h00);
  endtask

  always @(posedge ref_clk_i) begin
    cycle_count++;
    if (cycle_count == 8000) begin
      fail_count++;
      test_done();
    end
  end

  initial begin
    repeat (12) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    check("uop_rst", {4'h0, uop}, 8'h00);
    check("uop_oe_rst", {7'h00, uop_oe}, 8'h01);
    check("int_oe_rst", {7'h00, int_oe}, 8'h00);
    set_mode(1'b0, 1'b0);
    rd_chk("uop_reg_rst", 8'h14, 8'h00);
    // Ordinary cases: all writes first, then all reads
    for (int i = 0; i < 8; i++) begin
      set_mode(ROWS[i].style, ROWS[i].mux);
      wr(ROWS[i].addr, ROWS[i].data);
    end
    check("uop_pins", {4'h0, uop}, 8'h09);
    for (int i = 0; i < 8; i++) begin
      set_mode(ROWS[i].style, ROWS[i].mux);
      rd_chk("row_data", ROWS[i].addr, ROWS[i].data);
    end
    // Strobes without chip select must do nothing
    set_mode(1'b0, 1'b0);
    i_host.access(1'b1, 1'b0, 8'h05, 8'h77, rd, oe);
    i_host.access(1'b0, 1'b0, 8'h05, 8'h00, rd, oe);
    check("cs_off_oe", {7'h00, oe}, 8'h00);
    rd_chk("cs_off_data", 8'h05, 8'ha5);
    for (int b = 0; b < 2; b++) begin
      @(posedge ref_clk_i);
      bp_sel <= b[0];
      repeat (8) @(posedge ref_clk_i);
      check("utopia", {7'h00, utopia}, {7'h00, b[0]});
      check("tdm", {7'h00, tdm}, {7'h00, ~b[0]});
    end
    // Interrupt: masked event, unmask, clear
    @(posedge ref_clk_i);
    ev <= 8'h04;
    @(posedge ref_clk_i);
    ev <= 8'h00;
    repeat (4) @(posedge ref_clk_i);
    check("int_masked", {7'h00, int_oe}, 8'h00);
    wr(8'h21, 8'h04);
    check("int_on", {7'h00, int_oe}, 8'h01);
    check("int_level", {7'h00, int_n}, 8'h00);
    rd_chk("status", 8'h20, 8'h04);
    wr(8'h20, 8'h04);
    check("int_cleared", {7'h00, int_oe}, 8'h00);
    // Tri-state and register reset through the pin
    wr(8'h14, 8'h0f);
    check("uop_set", {4'h0, uop}, 8'h0f);
    @(posedge ref_clk_i);
    tst <= 1'b1;
    repeat (10) @(posedge ref_clk_i);
    check("float_uop", {7'h00, uop_oe}, 8'h00);
    check("float_bus", {7'h00, dout_oe}, 8'h00);
    check("float_int", {7'h00, int_oe}, 8'h00);
    tst <= 1'b0;
    repeat (10) @(posedge ref_clk_i);
    check("uop_clr", {4'h0, uop}, 8'h00);
    rd_chk("mask_clr", 8'h21, 8'h00);
    rd_chk("store_clr", 8'h85, 8'h00);
    test_done();
  end
endmodule
`default_nettype wire
